// ---- rtl/ppb_port_pins.sv ----
`default_nettype none
// What this block does
// - Shared oscillator/analog pins are held pulled down while reset is asserted
// - Option bit picks reset input or input port for the shared reset pin
// - Low on the shared reset pin before option fetch keeps device in reset
// - Output level change on an interrupt-capable output pin sets its request flag
// - Any analog select bit set disables port use of its pin
// - Single-bit instruction does byte-wide read-modify-write of the whole port
module ppb_port_pins
(
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        opt_pin_is_port,
  input  wire logic        reset_or_input_pin,
  input  wire logic [7:0]  port2_pin_in,
  input  wire logic [7:0]  port2_mode_wr,
  input  wire logic        port2_mode_we,
  input  wire logic [3:0]  analog_mode_select_bits,
  input  wire logic        analog_mode_we,
  input  wire logic [3:0]  pullup_option_bits,
  input  wire logic        pullup_we,
  input  wire logic [7:0]  port2_wr_data,
  input  wire logic        port2_byte_we,
  input  wire logic        port2_bit_we,
  input  wire logic [2:0]  port2_bit_sel,
  input  wire logic        port2_bit_val,
  input  wire logic        irq_a_clear,
  input  wire logic        irq_b_clear,
  output logic             internal_reset,
  output logic [7:0]       port2_pin_out,
  output logic [7:0]       port2_pin_oe,
  output logic [3:0]       port2_pullup_en,
  output logic             osc_out_analog2_pd,
  output logic             osc_in_analog3_pd,
  output logic [7:0]       port2_rd_data,
  output logic [3:0]       port2_analog_mode_ctrl,
  output logic             reset_or_input_val,
  output logic             ext_irq_flag_a,
  output logic             ext_irq_flag_b
);
  typedef struct packed
  {
    ppb_pkg::ppb_rst_e rst;
    logic [1:0]        cnt;
    logic              port_sel;
    logic [7:0]        latch;
    logic [7:0]        mode;
    logic [3:0]        ana;
    logic [3:0]        pu;
    logic [7:0]        rd;
    logic [7:0]        pin_out;
    logic [7:0]        pin_oe;
    logic [3:0]        pu_en;
    logic              pd;
    logic              rin;
    logic              fa;
    logic              fb;
    logic              ir;
  } ppb_state_s;

  ppb_state_s st_q;
  ppb_state_s st_d;
  logic       chg_a;
  logic       chg_b;

  // Pin is usable as a digital port only when its analog select is off
  function automatic logic [7:0] port_usable(input logic [3:0] ana);
    port_usable = {4'hF, ~ana};
  endfunction

  // Inputs read the pin, outputs read their own latch
  function automatic logic [7:0] read_back(input logic [7:0] mode, input logic [7:0] pin, input logic [7:0] latch);
    read_back = (mode & pin) | (~mode & latch);
  endfunction

  // ----------------------------------------------------------------
  // Interrupt pin level change detectors
  // ----------------------------------------------------------------
  ppb_irq_edge u_edge_a
  (
    .mclk      (mclk),
    .reset     (reset),
    .out_mode  (~st_q.mode[ppb_pkg::IRQ_A_BIT]),
    .out_level (st_q.latch[ppb_pkg::IRQ_A_BIT]),
    .change    (chg_a)
  );
  ppb_irq_edge u_edge_b
  (
    .mclk      (mclk),
    .reset     (reset),
    .out_mode  (~st_q.mode[ppb_pkg::IRQ_B_BIT]),
    .out_level (st_q.latch[ppb_pkg::IRQ_B_BIT]),
    .change    (chg_b)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [7:0] rmw;
    logic [7:0] use_m;
    rmw = 8'h00;
    use_m = 8'h00;
    st_d = st_q;
    case (st_q.rst)
      ppb_pkg::PPB_RST_HOLD:
      begin
        st_d.cnt = 2'h0;
        st_d.rst = ppb_pkg::PPB_RST_FETCH;
      end
      ppb_pkg::PPB_RST_FETCH:
      begin
        // Pin still acts as reset until the option is known
        if (!reset_or_input_pin)
        begin
          st_d.cnt = 2'h0;
        end
        else if (st_q.cnt == ppb_pkg::OPT_FETCH_LAST)
        begin
          st_d.port_sel = opt_pin_is_port;
          st_d.rst = ppb_pkg::PPB_RST_RUN;
        end
        else
        begin
          st_d.cnt = st_q.cnt + 2'h1;
        end
      end
      ppb_pkg::PPB_RST_RUN:
      begin
        if (!st_q.port_sel && !reset_or_input_pin)
        begin
          st_d.rst = ppb_pkg::PPB_RST_HOLD;
        end
      end
      default:
      begin
        st_d.rst = ppb_pkg::PPB_RST_HOLD;
      end
    endcase
    if (st_q.rst == ppb_pkg::PPB_RST_RUN)
    begin
      if (port2_mode_we)
      begin
        st_d.mode = port2_mode_wr;
      end
      if (analog_mode_we)
      begin
        st_d.ana = analog_mode_select_bits;
      end
      if (pullup_we)
      begin
        st_d.pu = pullup_option_bits;
      end
      // Read back pin level for inputs, latch for outputs, as a whole byte
      rmw = read_back(st_q.mode, port2_pin_in, st_q.latch);
      if (port2_bit_we)
      begin
        rmw[port2_bit_sel] = port2_bit_val;
        st_d.latch = rmw;
      end
      else if (port2_byte_we)
      begin
        st_d.latch = port2_wr_data;
      end
    end
    // Clear loses to a same-cycle set
    if (irq_a_clear)
    begin
      st_d.fa = 1'b0;
    end
    if (irq_b_clear)
    begin
      st_d.fb = 1'b0;
    end
    if (chg_a)
    begin
      st_d.fa = 1'b1;
    end
    if (chg_b)
    begin
      st_d.fb = 1'b1;
    end
    use_m = port_usable(st_d.ana);
    st_d.pin_oe = ~st_d.mode & use_m;
    st_d.pin_out = st_d.latch & use_m;
    st_d.pu_en = st_d.pu & ~st_d.ana;
    st_d.rd = read_back(st_d.mode, port2_pin_in, st_d.latch) & use_m;
    st_d.pd = 1'b0;
    st_d.rin = st_d.port_sel & reset_or_input_pin;
    // Registered so the reset output never glitches on a state decode
    st_d.ir = (st_d.rst != ppb_pkg::PPB_RST_RUN);
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      st_q.rst     <= ppb_pkg::PPB_RST_HOLD;
      st_q.cnt     <= 2'h0;
      st_q.port_sel <= 1'b0;
      st_q.latch   <= ppb_pkg::LATCH_RST;
      st_q.mode    <= ppb_pkg::MODE_RST;
      st_q.ana     <= ppb_pkg::ANA_RST;
      st_q.pu      <= 4'h0;
      st_q.rd      <= 8'h00;
      st_q.pin_out <= 8'h00;
      st_q.pin_oe  <= 8'h00;
      st_q.pu_en   <= 4'h0;
      st_q.pd      <= 1'b1;
      st_q.rin     <= 1'b0;
      st_q.fa      <= 1'b0;
      st_q.fb      <= 1'b0;
      st_q.ir      <= 1'b1;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign internal_reset         = st_q.ir;
  assign port2_pin_out          = st_q.pin_out;
  assign port2_pin_oe           = st_q.pin_oe;
  assign port2_pullup_en        = st_q.pu_en;
  assign osc_out_analog2_pd     = st_q.pd;
  assign osc_in_analog3_pd      = st_q.pd;
  assign port2_rd_data          = st_q.rd;
  assign port2_analog_mode_ctrl = st_q.ana;
  assign reset_or_input_val     = st_q.rin;
  assign ext_irq_flag_a         = st_q.fa;
  assign ext_irq_flag_b         = st_q.fb;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_pd_after_reset: assert property (@(posedge mclk) $fell(reset) |-> osc_out_analog2_pd && osc_in_analog3_pd)
    else $error("pull-down not held through reset");
  a_pd_released: assert property (@(posedge mclk) disable iff (reset) $past(!reset) |=> !osc_in_analog3_pd)
    else $error("pull-down not released");
  a_pin_reset_only: assert property (@(posedge mclk) disable iff (reset)
      st_q.rst == ppb_pkg::PPB_RST_RUN && st_q.port_sel |=> st_q.rst == ppb_pkg::PPB_RST_RUN)
    else $error("port mode pin caused reset");
  a_pin_low_reset: assert property (@(posedge mclk) disable iff (reset)
      st_q.rst == ppb_pkg::PPB_RST_RUN && !st_q.port_sel && !reset_or_input_pin |=> internal_reset)
    else $error("reset pin ignored");
  a_fetch_hold: assert property (@(posedge mclk) disable iff (reset)
      st_q.rst == ppb_pkg::PPB_RST_FETCH && !reset_or_input_pin |=> internal_reset)
    else $error("left reset with pin low");
  a_irq_set: assert property (@(posedge mclk) disable iff (reset) chg_a |=> ext_irq_flag_a)
    else $error("irq a flag not set");
  a_irq_b_set: assert property (@(posedge mclk) disable iff (reset) chg_b |=> ext_irq_flag_b)
    else $error("irq b flag not set");
  a_analog_off: assert property (@(posedge mclk) disable iff (reset)
      (port2_pin_oe[3:0] & port2_analog_mode_ctrl) == 4'h0)
    else $error("analog pin driven");
  a_bit_rmw: assert property (@(posedge mclk) disable iff (reset)
      port2_bit_we && !internal_reset && !port2_byte_we |=> st_q.latch[$past(port2_bit_sel)] == $past(port2_bit_val))
    else $error("bit write lost");
endmodule
`default_nettype wire

// ---- shared/ppb_pkg.sv ----
`default_nettype none
package ppb_pkg;
  // Port 2 is eight bits wide; pins 0..3 double as analog inputs
  localparam int unsigned PORT_W       = 8;
  localparam int unsigned ANA_W        = 4;
  localparam int unsigned OSC_OUT_BIT  = 2;
  localparam int unsigned OSC_IN_BIT   = 3;
  localparam int unsigned IRQ_A_BIT    = 1;
  localparam int unsigned IRQ_B_BIT    = 2;
  localparam logic [7:0]  LATCH_RST    = 8'h00;
  localparam logic [7:0]  MODE_RST     = 8'hFF;
  localparam logic [3:0]  ANA_RST      = 4'h0;
  // Cycles the option byte fetch takes after reset release
  localparam int unsigned OPT_FETCH_CYC = 2;
  localparam logic [1:0]  OPT_FETCH_LAST = 2'(OPT_FETCH_CYC - 1);
  typedef enum logic [1:0] {PPB_RST_HOLD, PPB_RST_FETCH, PPB_RST_RUN} ppb_rst_e;
endpackage
`default_nettype wire

// ---- rtl/ppb_irq_edge.sv ----
`default_nettype none
// Output level change detector for one interrupt-capable pin
module ppb_irq_edge
(
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic out_mode,
  input  wire logic out_level,
  output logic      change
);
  typedef struct packed
  {
    logic lvl;
  } ppb_edge_s;
  ppb_edge_s st_q;
  ppb_edge_s st_d;
  always_comb
  begin
    st_d.lvl = out_level;
  end
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end
  assign change = out_mode && (out_level != st_q.lvl);
endmodule
`default_nettype wire

// ---- testbench/ppb_board.sv ----
`default_nettype none
// ----------------------------------------
// Board circuitry on the port pins
// ----------------------------------------
module ppb_board
(
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [3:0] pu_en,
  input  wire logic       pd2,
  input  wire logic       pd3,
  input  wire logic [7:0] ext,
  output logic      [7:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] pull;
  // Released pins settle to their pull, never to the last driven level
  always_comb
  begin
    pull = {ext[7:4], ext[3:0] | pu_en};
    pull[2] = pd2 ? 1'b0 : pull[2];
    pull[3] = pd3 ? 1'b0 : pull[3];
    pin_in = (pin_oe & pin_out) | (~pin_oe & pull);
  end
endmodule
`default_nettype wire

// ---- testbench/port_pin_behaviour_notes_bench.sv ----
`default_nettype none
module port_pin_behaviour_notes_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int MD = 16, AN = 8, PU = 4, BY = 2, BI = 1;
  logic mclk, reset, opt_pin_is_port, reset_or_input_pin, port2_mode_we, analog_mode_we, pullup_we;
  logic port2_byte_we, port2_bit_we, port2_bit_val, irq_a_clear, irq_b_clear, internal_reset;
  logic osc_out_analog2_pd, osc_in_analog3_pd, reset_or_input_val, ext_irq_flag_a, ext_irq_flag_b;
  logic [7:0] port2_pin_in, port2_mode_wr, port2_wr_data, port2_pin_out, port2_pin_oe, port2_rd_data, ext;
  logic [3:0] analog_mode_select_bits, pullup_option_bits, port2_pullup_en, port2_analog_mode_ctrl;
  logic [2:0] port2_bit_sel;
  int fail_count, total_checks;

  ppb_port_pins ppb_port_pins_inst
  (
    .mclk, .reset, .opt_pin_is_port, .reset_or_input_pin, .port2_pin_in, .port2_mode_wr, .port2_mode_we,
    .analog_mode_select_bits, .analog_mode_we, .pullup_option_bits, .pullup_we, .port2_wr_data,
    .port2_byte_we, .port2_bit_we, .port2_bit_sel, .port2_bit_val, .irq_a_clear, .irq_b_clear,
    .internal_reset, .port2_pin_out, .port2_pin_oe, .port2_pullup_en, .osc_out_analog2_pd,
    .osc_in_analog3_pd, .port2_rd_data, .port2_analog_mode_ctrl, .reset_or_input_val,
    .ext_irq_flag_a, .ext_irq_flag_b
  );

  ppb_board ppb_board_inst
  (
    .pin_out(port2_pin_out), .pin_oe(port2_pin_oe), .pu_en(port2_pullup_en),
    .pd2(osc_out_analog2_pd), .pd3(osc_in_analog3_pd), .ext(ext), .pin_in(port2_pin_in)
  );

  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask

  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    total_checks++;
    if (s !== e)
    begin
      fail_count++;
      $display("unexpected %s exp %h seen %h", n, e, s);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // One data value feeds every write port; only the strobed one takes it
  task automatic wr(input logic [4:0] we, input logic [7:0] d);
    port2_mode_wr = d;
    analog_mode_select_bits = d[3:0];
    pullup_option_bits = d[3:0];
    port2_wr_data = d;
    port2_bit_sel = d[2:0];
    port2_bit_val = d[7];
    {port2_mode_we, analog_mode_we, pullup_we, port2_byte_we, port2_bit_we} = we;
    step(1);
    {port2_mode_we, analog_mode_we, pullup_we, port2_byte_we, port2_bit_we} = '0;
    step(2);
  endtask

  task automatic wait_run();
    for (int i = 0; i < 20 && internal_reset !== 1'b0; i++)
      step(1);
    chk("run", internal_reset, 1'b0);
    if (internal_reset !== 1'b0)
      end_sim();
  endtask

  task automatic rst(input logic opt);
    opt_pin_is_port = opt;
    reset = 1'b1;
    step(3);
    chk("pd", {osc_out_analog2_pd, osc_in_analog3_pd}, 2'b11);
    reset = 1'b0;
    step(1);
    chk("pd", {osc_out_analog2_pd, osc_in_analog3_pd}, 2'b00);
    wait_run();
  endtask

  task automatic clr();
    {irq_a_clear, irq_b_clear} = 2'b11;
    step(1);
    {irq_a_clear, irq_b_clear} = 2'b00;
    step(1);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial
  begin
    {reset, opt_pin_is_port, port2_mode_we, analog_mode_we, pullup_we, port2_byte_we} = 6'h20;
    {port2_bit_we, port2_bit_val, irq_a_clear, irq_b_clear} = '0;
    {port2_mode_wr, port2_wr_data, ext, port2_bit_sel} = '0;
    {analog_mode_select_bits, pullup_option_bits} = '0;
    reset_or_input_pin = 1'b1;
    rst(1'b0);
    reset_or_input_pin = 1'b0;
    step(3);
    chk("hold", internal_reset, 1'b1);
    reset_or_input_pin = 1'b1;
    wait_run();
    wr(MD, 8'h00);
    wr(BY, 8'hFF);
    wr(AN, 8'h05);
    wr(PU, 8'h0A);
    chk("oe", port2_pin_oe, 8'hFA);
    chk("rd", port2_rd_data, 8'hFA);
    chk("ana", port2_analog_mode_ctrl, 4'h5);
    chk("pu", port2_pullup_en, 4'hA);
    wr(AN, 8'h00);
    wr(MD, 8'hF0);
    wr(BY, 8'h00);
    ext = 8'hA0;
    wr(BI, 8'h80);
    wr(MD, 8'h00);
    chk("rmw", port2_pin_out, 8'hA1);
    clr();
    wr(BI, 8'h81);
    chk("fa", {ext_irq_flag_a, ext_irq_flag_b}, 2'b10);
    wr(BI, 8'h82);
    chk("fb", ext_irq_flag_b, 1'b1);
    wr(MD, 8'h06);
    clr();
    wr(BY, 8'h00);
    chk("fin", {ext_irq_flag_a, ext_irq_flag_b}, 2'b00);
    rst(1'b1);
    reset_or_input_pin = 1'b0;
    step(3);
    chk("port", {internal_reset, reset_or_input_val}, 2'b00);
    reset_or_input_pin = 1'b1;
    step(2);
    chk("val", reset_or_input_val, 1'b1);
    end_sim();
  end
endmodule
`default_nettype wire
